/* hw/as_cfg_pkg.sv */
package as_cfg_pkg;

    // clock and link rates
    localparam int          CORE_CLK_MHZ      = 100;
    localparam int          FAST_OSC_MHZ      = 40;
    localparam int          SLOW_OSC_MHZ      = 20;
    // half period of the link clock, rounded up so the rate never exceeds the setting
    localparam logic [1:0]  HALF_FAST_CYCLES  =
        2'((CORE_CLK_MHZ + 2 * FAST_OSC_MHZ - 1) / (2 * FAST_OSC_MHZ));
    localparam logic [1:0]  HALF_SLOW_CYCLES  =
        2'((CORE_CLK_MHZ + 2 * SLOW_OSC_MHZ - 1) / (2 * SLOW_OSC_MHZ));

    // start-up clocking
    localparam int          INIT_OSC_MHZ      = 10;
    localparam logic [3:0]  INIT_TICK_CYCLES  = 4'(CORE_CLK_MHZ / INIT_OSC_MHZ);
    localparam logic [31:0] INIT_CLOCKS       = 32'd299;
    localparam logic [31:0] CFG_TO_USER_DELAY = INIT_CLOCKS;
    localparam int          RESTART_US        = 40;
    localparam logic [31:0] RESTART_CYCLES    = 32'(RESTART_US * CORE_CLK_MHZ);

    // flash read sequence and bitstream framing
    localparam logic [31:0] CMD_BITS          = 32'd32;
    localparam logic [7:0]  READ_CMD          = 8'h03;
    localparam logic [31:0] SYNC_BITS         = 32'd8;
    localparam logic [7:0]  SYNC_PATTERN      = 8'h6a;
    localparam logic [31:0] INITDONE_BIT      = 32'd8;

    // register map, byte offsets
    localparam logic [3:0]  REG_CTRL          = 4'h0;
    localparam logic [3:0]  REG_STATUS        = 4'h4;
    localparam logic [3:0]  REG_LENGTH        = 4'h8;
    localparam logic [3:0]  REG_ADDR          = 4'hc;
    localparam int          CTRL_AUTORESTART  = 0;
    localparam int          CTRL_USERCLK      = 1;
    localparam logic [1:0]  CTRL_RST          = 2'h1;
    localparam logic [31:0] LENGTH_RST        = 32'h0000_1000;
    localparam logic [23:0] ADDR_RST          = 24'h00_0000;
    localparam int          MODE_SELECT_PINS_FAST         = 1;

    typedef enum logic [6:0] {
        ST_RESET   = 7'h01,
        ST_CMD     = 7'h02,
        ST_DATA    = 7'h04,
        ST_RELEASE = 7'h08,
        ST_INIT    = 7'h10,
        ST_USER    = 7'h20,
        ST_ERROR   = 7'h40
    } cfg_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } avs_req_s;

    typedef struct packed {
        logic flashSelectOutN;
        logic flashSelectOe;
        logic serialCmdOut;
        logic serialCmdOe;
        logic linkSerialClock;
        logic linkClockOe;
    } link_out_s;

endpackage

/* hw/active_serial_config_sequencer.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps

// Behaviour
// - link clock from own oscillator, mode-selected
// - link clock within range for setting
// - outputs change, data sampled on falling
// - select flash low when configuring
// - shift read command and address out
// - release load-complete, stop link clock when done
// - initialize only after load-complete high
// - link pins tri-stated after configuration
// - start-up clock internal or user pin
// - 299 start-up clocks, user clock max 100MHz; edges are sampled on the 100MHz core clock, so only below 50MHz
// - wait indefinitely for user start-up clocks
// - start-up-finished low, released at user mode
// - without it, fixed count or delay
// - reconfig low resets, drives status, done low
// - frame error drives status low
// - auto-restart holds status low, releases after 40us
// - held in reset while reconfig or status low
// - configure once status line reads high
module active_serial_config_sequencer
    import as_cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire avs_req_s    avsReq,
    output logic             avsWaitrequest,
    output logic [31:0]      avsReaddata,
    output link_out_s        linkOut,
    input  wire logic        serialCfgDataIn,
    input  wire logic [1:0]  modeSelectPins,
    input  wire logic        userStartupClock,
    input  wire logic        reconfigReqN,
    input  wire logic        loadCompleteIn,
    output logic             loadCompleteOut,
    output logic             loadCompleteOe,
    input  wire logic        statusInN,
    output logic             statusOutN,
    output logic             statusOe,
    output logic             initDoneOut,
    output logic             initDoneOe,
    output logic             userMode
);

    typedef struct packed {
        cfg_state_e  state;
        logic        reqS1;
        logic        reqS2;
        logic        statS1;
        logic        statS2;
        logic        ldS1;
        logic        ldS2;
        logic        dataS1;
        logic        dataS2;
        logic        usrS1;
        logic        usrS2;
        logic        usrPrev;
        logic [1:0]  mselS1;
        logic [1:0]  mselS2;
        logic        fast;
        logic [1:0]  divCnt;
        logic        dataArmed;
        logic [31:0] cnt;
        logic [31:0] shift;
        logic [7:0]  syncSh;
        logic [3:0]  tickCnt;
        link_out_s   link;
        logic        loadOe;
        logic        statusOe;
        logic        initDoneOe;
        logic        userMode;
        logic        errSeen;
        logic [1:0]  ctrl;
        logic [31:0] length;
        logic [23:0] startAddr;
        logic        waitReq;
        logic [31:0] rdData;
    } state_s;

    state_s     s_r;
    state_s     s_nxt;
    logic [1:0] halfCycles;
    logic       toggle;
    logic       fallEdge;
    logic       initTick;
    logic [7:0] syncNow;

    assign linkOut         = s_r.link;
    assign loadCompleteOut = 1'b0;
    assign loadCompleteOe  = s_r.loadOe;
    assign statusOutN      = 1'b0;
    assign statusOe        = s_r.statusOe;
    assign initDoneOut     = 1'b0;
    assign initDoneOe      = s_r.initDoneOe;
    assign userMode        = s_r.userMode;
    assign avsWaitrequest  = s_r.waitReq;
    assign avsReaddata     = s_r.rdData;

    always_comb begin
        s_nxt = s_r;
        // two-stage synchronisers for every pin input
        s_nxt.reqS1   = reconfigReqN;
        s_nxt.reqS2   = s_r.reqS1;
        s_nxt.statS1  = statusInN;
        s_nxt.statS2  = s_r.statS1;
        s_nxt.ldS1    = loadCompleteIn;
        s_nxt.ldS2    = s_r.ldS1;
        s_nxt.dataS1  = serialCfgDataIn;
        s_nxt.dataS2  = s_r.dataS1;
        s_nxt.usrS1   = userStartupClock;
        s_nxt.usrS2   = s_r.usrS1;
        s_nxt.usrPrev = s_r.usrS2;
        s_nxt.mselS1  = modeSelectPins;
        s_nxt.mselS2  = s_r.mselS1;

        // bus slave: one wait cycle, then the answer stands for one edge
        s_nxt.waitReq = 1'b1;
        if ((avsReq.read || avsReq.write) && s_r.waitReq) begin
            s_nxt.waitReq = 1'b0;
            case (avsReq.address)
                REG_CTRL:   s_nxt.rdData = {30'h0, s_r.ctrl};
                REG_STATUS: s_nxt.rdData = {23'h0, s_r.state, s_r.errSeen, s_r.userMode};
                REG_LENGTH: s_nxt.rdData = s_r.length;
                REG_ADDR:   s_nxt.rdData = {8'h00, s_r.startAddr};
                default:    s_nxt.rdData = 32'h0;
            endcase
        end
        if (avsReq.write && !s_r.waitReq) begin
            case (avsReq.address)
                REG_CTRL:   s_nxt.ctrl = avsReq.writedata[1:0];
                REG_LENGTH: s_nxt.length = avsReq.writedata;
                REG_ADDR:   s_nxt.startAddr = avsReq.writedata[23:0];
                default:    ;
            endcase
        end

        // link clock divider, runs only while the flash is being read
        halfCycles = s_r.fast ? HALF_FAST_CYCLES : HALF_SLOW_CYCLES;
        toggle     = 1'b0;
        if (s_r.state == ST_CMD || s_r.state == ST_DATA) begin
            if (s_r.divCnt == halfCycles - 2'h1) begin
                s_nxt.divCnt = 2'h0;
                toggle = 1'b1;
                s_nxt.link.linkSerialClock = ~s_r.link.linkSerialClock;
            end else begin
                s_nxt.divCnt = s_r.divCnt + 2'h1;
            end
        end
        fallEdge = toggle & s_r.link.linkSerialClock;

        // start-up clock source
        initTick = 1'b0;
        if (s_r.ctrl[CTRL_USERCLK]) begin
            initTick = s_r.usrS2 & ~s_r.usrPrev;
        end else if (s_r.tickCnt == INIT_TICK_CYCLES - 4'h1) begin
            initTick = 1'b1;
        end
        if (s_r.tickCnt == INIT_TICK_CYCLES - 4'h1) begin
            s_nxt.tickCnt = 4'h0;
        end else begin
            s_nxt.tickCnt = s_r.tickCnt + 4'h1;
        end

        syncNow = {s_r.syncSh[6:0], s_r.dataS2};

        case (s_r.state)
            ST_RESET: begin
                s_nxt.statusOe = ~s_r.reqS2;
                s_nxt.loadOe   = 1'b1;
                s_nxt.userMode = 1'b0;
                if (s_r.reqS2 && !s_r.statusOe && s_r.statS2) begin
                    s_nxt.state     = ST_CMD;
                    s_nxt.fast      = s_r.mselS2[MODE_SELECT_PINS_FAST];
                    s_nxt.divCnt    = 2'h0;
                    s_nxt.cnt       = 32'h0;
                    s_nxt.shift     = {READ_CMD, s_r.startAddr};
                    s_nxt.errSeen   = 1'b0;
                    s_nxt.dataArmed = 1'b0;
                    s_nxt.link      = '{flashSelectOutN: 1'b0, flashSelectOe: 1'b1,
                                        serialCmdOut: READ_CMD[7], serialCmdOe: 1'b1,
                                        linkSerialClock: 1'b0, linkClockOe: 1'b1};
                end
            end
            ST_CMD: begin
                if (fallEdge) begin
                    s_nxt.cnt   = s_r.cnt + 32'h1;
                    s_nxt.shift = {s_r.shift[30:0], 1'b0};
                    s_nxt.link.serialCmdOut = s_r.shift[30];
                    if (s_r.cnt == CMD_BITS - 32'h1) begin
                        s_nxt.state = ST_DATA;
                        s_nxt.cnt   = 32'h0;
                    end
                end
            end
            ST_DATA: begin
                // the first falling edge is where the flash puts out bit 0
                if (fallEdge && !s_r.dataArmed) begin
                    s_nxt.dataArmed = 1'b1;
                end else if (fallEdge) begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                    if (s_r.cnt < SYNC_BITS) begin
                        s_nxt.syncSh = syncNow;
                    end
                    if (s_r.cnt == INITDONE_BIT) begin
                        s_nxt.initDoneOe = s_r.dataS2;
                    end
                    if (s_r.cnt == SYNC_BITS - 32'h1 && syncNow != SYNC_PATTERN) begin
                        s_nxt.state    = ST_ERROR;
                        s_nxt.cnt      = 32'h0;
                        s_nxt.statusOe = 1'b1;
                        s_nxt.errSeen  = 1'b1;
                        s_nxt.link     = '{flashSelectOutN: 1'b1, flashSelectOe: 1'b1,
                                           serialCmdOut: 1'b1, serialCmdOe: 1'b0,
                                           linkSerialClock: 1'b0, linkClockOe: 1'b0};
                    end else if (s_r.cnt == s_r.length - 32'h1) begin
                        s_nxt.state  = ST_RELEASE;
                        s_nxt.loadOe = 1'b0;
                        s_nxt.link   = '{flashSelectOutN: 1'b1, flashSelectOe: 1'b0,
                                         serialCmdOut: 1'b1, serialCmdOe: 1'b0,
                                         linkSerialClock: 1'b0, linkClockOe: 1'b0};
                    end
                end
            end
            ST_RELEASE: begin
                if (s_r.ldS2) begin
                    s_nxt.state = ST_INIT;
                    s_nxt.cnt   = 32'h0;
                end
            end
            ST_INIT: begin
                if (initTick) begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                    if (s_r.cnt == (s_r.ctrl[CTRL_USERCLK] ? INIT_CLOCKS
                                    : CFG_TO_USER_DELAY) - 32'h1) begin
                        s_nxt.state      = ST_USER;
                        s_nxt.initDoneOe = 1'b0;
                        s_nxt.userMode   = 1'b1;
                    end
                end
            end
            ST_USER: begin
                s_nxt.userMode = 1'b1;
            end
            ST_ERROR: begin
                s_nxt.statusOe = 1'b1;
                s_nxt.loadOe   = 1'b1;
                if (s_r.ctrl[CTRL_AUTORESTART]) begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                    if (s_r.cnt == RESTART_CYCLES - 32'h1) begin
                        s_nxt.state    = ST_RESET;
                        s_nxt.statusOe = 1'b0;
                        s_nxt.link.flashSelectOe = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_RESET;
            end
        endcase

        // external status low aborts configuration, as does a reconfiguration request
        if (!s_r.statS2 && !s_r.statusOe && (s_r.state == ST_CMD || s_r.state == ST_DATA
                || s_r.state == ST_RELEASE || s_r.state == ST_INIT)) begin
            s_nxt.state = ST_RESET;
        end
        if (!s_r.reqS2 && s_r.state != ST_RESET) begin
            s_nxt.state      = ST_RESET;
            s_nxt.statusOe   = 1'b1;
            s_nxt.loadOe     = 1'b1;
            s_nxt.userMode   = 1'b0;
            s_nxt.initDoneOe = 1'b0;
        end
        if (s_nxt.state == ST_RESET && s_r.state != ST_RESET) begin
            s_nxt.initDoneOe = 1'b0;
            s_nxt.link = '{flashSelectOutN: 1'b1, flashSelectOe: 1'b0,
                           serialCmdOut: 1'b1, serialCmdOe: 1'b0,
                           linkSerialClock: 1'b0, linkClockOe: 1'b0};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '{state: ST_RESET, reqS1: 1'b0, reqS2: 1'b0, statS1: 1'b0,
                     statS2: 1'b0, ldS1: 1'b0, ldS2: 1'b0, dataS1: 1'b0, dataS2: 1'b0,
                     usrS1: 1'b0, usrS2: 1'b0, usrPrev: 1'b0, mselS1: 2'h0, mselS2: 2'h0,
                     fast: 1'b0, divCnt: 2'h0, dataArmed: 1'b0, cnt: 32'h0, shift: 32'h0,
                     syncSh: 8'h00, tickCnt: 4'h0,
                     link: '{flashSelectOutN: 1'b1, flashSelectOe: 1'b0,
                             serialCmdOut: 1'b1, serialCmdOe: 1'b0,
                             linkSerialClock: 1'b0, linkClockOe: 1'b0},
                     loadOe: 1'b1, statusOe: 1'b1, initDoneOe: 1'b0, userMode: 1'b0,
                     errSeen: 1'b0, ctrl: CTRL_RST, length: LENGTH_RST,
                     startAddr: ADDR_RST, waitReq: 1'b1, rdData: 32'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence clkRiseFast;
        $rose(s_r.link.linkSerialClock) && s_r.fast && s_r.state == ST_DATA;
    endsequence
    sequence clkHighThenFall;
        s_r.link.linkSerialClock[*2] ##1 (!s_r.link.linkSerialClock || s_r.state != ST_DATA);
    endsequence

    a_fast_half_period: assert property (clkRiseFast |-> clkHighThenFall)
        else $error("fast link clock half period is not two cycles");
    a_cmd_on_fall: assert property (
        ($changed(s_r.link.serialCmdOut) && s_r.state == ST_CMD && $past(s_r.state) == ST_CMD)
            |-> $fell(s_r.link.linkSerialClock))
        else $error("command bit changed off a falling link edge");
    a_select_low_cmd: assert property (
        s_r.state == ST_CMD |-> !s_r.link.flashSelectOutN && s_r.link.flashSelectOe)
        else $error("flash not selected while shifting command");
    a_release_done: assert property (
        $rose(s_r.state == ST_RELEASE) |-> !s_r.loadOe && !s_r.link.linkClockOe
            ##1 !s_r.link.linkSerialClock)
        else $error("load-complete or link clock still driven after load");
    a_init_waits_done: assert property (
        $rose(s_r.state == ST_INIT) |-> $past(s_r.ldS2))
        else $error("initialization began before load-complete high");
    a_pins_tristate: assert property (
        (s_r.state == ST_INIT || s_r.state == ST_USER)
            |-> !s_r.link.serialCmdOe && !s_r.link.linkClockOe && !s_r.link.flashSelectOe)
        else $error("link pins driven after configuration");
    a_init_count: assert property (
        $rose(s_r.userMode) |-> $past(s_r.cnt) == INIT_CLOCKS - 32'h1)
        else $error("user mode entered after wrong start-up count");
    a_initdone_release: assert property (
        $rose(s_r.userMode) |-> !s_r.initDoneOe && s_r.state == ST_USER)
        else $error("start-up-finished still driven in user mode");
    a_reconfig_reset: assert property (
        (!s_r.reqS2 && s_r.state != ST_RESET)
            |=> s_r.state == ST_RESET && s_r.statusOe && s_r.loadOe)
        else $error("reconfiguration request did not reset");
    a_error_status: assert property (
        s_r.state == ST_ERROR |-> s_r.statusOe && s_r.loadOe)
        else $error("error state without status and load-complete low");
    a_restart_time: assert property (
        (s_r.state == ST_ERROR && s_r.ctrl[CTRL_AUTORESTART] && s_r.reqS2
            && s_r.cnt == RESTART_CYCLES - 32'h1)
            |=> s_r.state == ST_RESET && !s_r.statusOe)
        else $error("auto-restart did not release status on time");

endmodule

/* testbench/flash_model.sv */
`timescale 1ns/100ps
module flash_model
    import as_cfg_pkg::*;
(
    input  wire logic   sclk,
    input  wire logic   selN,
    input  wire logic   cmdIn,
    input  wire logic   badSync,
    output logic        dataOut,
    output logic [31:0] cmdSeen
);
    logic [15:0] frame;
    int          nCmd;
    int          idx;
    // second byte msb set so the start-up-finished output gets enabled
    assign frame = {badSync ? 8'h5a : SYNC_PATTERN, 8'h95};
    initial begin
        dataOut = 1'b1;
        cmdSeen = '0;
        nCmd = 0;
        idx = 0;
    end
    // deselect ends the read; released data line is pulled high
    always @(posedge selN) begin
        nCmd = 0;
        idx = 0;
        dataOut = 1'b1;
    end
    always @(posedge sclk) begin
        if (!selN && nCmd < 32) begin
            cmdSeen = {cmdSeen[30:0], cmdIn};
            nCmd = nCmd + 1;
        end
    end
    always @(negedge sclk) begin
        if (!selN && nCmd == 33) begin
            dataOut = frame[15 - idx % 16];
            idx = idx + 1;
        end else if (!selN && nCmd == 32) begin
            // the fall that ends the command carries no data yet
            nCmd = 33;
        end
    end
endmodule

/* testbench/active_serial_config_sequencer_tb.sv */
`timescale 1ns/100ps
module active_serial_config_sequencer_tb;
    import as_cfg_pkg::*;
    logic        core_clk;
    logic        rst;
    avs_req_s    avsReq;
    logic        avsWaitrequest;
    logic [31:0] avsReaddata;
    link_out_s   linkOut;
    logic        dataIn;
    logic [1:0]  mode_select_pins;
    logic        uclk;
    logic        reqN;
    logic        loadOe;
    logic        statusOe;
    logic        initOe;
    logic        userMode;
    logic        badSync;
    logic [31:0] cmdSeen;
    logic [31:0] rd;
    int          n_mismatch;
    int          total_checks;
    int          cyc;
    int          lastRise;
    int          linkPer;
    int          n;
    logic        prevClk;
    wire         selW = linkOut.flashSelectOe ? linkOut.flashSelectOutN : 1'b1;
    wire         clkW = linkOut.linkClockOe ? linkOut.linkSerialClock : 1'b1;
    wire         cmdW = linkOut.serialCmdOe ? linkOut.serialCmdOut : 1'b1;
    wire         loadW = !loadOe;
    wire         statW = !statusOe;
    wire         initW = !initOe;

    active_serial_config_sequencer u_dut (.core_clk(core_clk), .rst(rst), .avsReq(avsReq),
        .avsWaitrequest(avsWaitrequest), .avsReaddata(avsReaddata), .linkOut(linkOut),
        .serialCfgDataIn(dataIn), .modeSelectPins(mode_select_pins), .userStartupClock(uclk),
        .reconfigReqN(reqN), .loadCompleteIn(loadW), .loadCompleteOut(),
        .loadCompleteOe(loadOe), .statusInN(statW), .statusOutN(), .statusOe(statusOe),
        .initDoneOut(), .initDoneOe(initOe), .userMode(userMode));
    flash_model u_flash (.sclk(clkW), .selN(selW), .cmdIn(cmdW), .badSync(badSync),
        .dataOut(dataIn), .cmdSeen(cmdSeen));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // link clock period in core cycles, rising edge to rising edge
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        prevClk <= clkW;
        if (clkW && !prevClk) begin
            linkPer <= cyc - lastRise;
            lastRise <= cyc;
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        avsReq <= '{read: !wr, write: wr, address: a, writedata: d};
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsReq <= '0;
        chk("wait cycles", 32'd2, k);
    endtask
    task automatic pulse_req(input logic tog);
        reqN <= 1'b0;
        repeat (25) begin
            tick(4);
            uclk <= tog;
            tick(4);
            uclk <= 1'b0;
        end
        chk("userMode in reset", 32'h0, {31'h0, userMode});
        chk("status in reset", 32'h0, {31'h0, statW});
        chk("load in reset", 32'h0, {31'h0, loadW});
        reqN <= 1'b1;
    endtask
    task automatic wait_user();
        for (n = 0; n < 30000 && userMode !== 1'b1; n++) tick(1);
        chk("userMode", 32'h1, {31'h0, userMode});
    endtask
    task automatic wait_error();
        for (n = 0; n < 3000 && statW !== 1'b1; n++) tick(1);
        for (n = 0; n < 3000 && statW !== 1'b0; n++) tick(1);
        chk("status on error", 32'h0, {31'h0, statW});
        tick(2);
        chk("load on error", 32'h0, {31'h0, loadW});
    endtask

    task automatic t_regs();
        bus(0, REG_CTRL, 0);
        chk("CTRL reset", 32'h1, rd);
        bus(0, REG_LENGTH, 0);
        chk("LENGTH reset", 32'h0000_1000, rd);
        bus(0, REG_ADDR, 0);
        chk("ADDR reset", 32'h0, rd);
        bus(1, REG_STATUS, 32'hffff_ffff);
        bus(0, REG_STATUS, 0);
        chk("STATUS held", 32'h0000_0004, rd);
        bus(0, 4'h1, 0);
        chk("unmapped", 32'h0, rd);
        bus(1, REG_LENGTH, 32'd24);
        bus(1, REG_ADDR, 32'h0012_3456);
        bus(0, REG_ADDR, 0);
        chk("ADDR", 32'h0012_3456, rd);
        $display("test regs done");
    endtask
    task automatic t_boot();
        mode_select_pins <= 2'b10;
        reqN <= 1'b1;
        for (n = 0; n < 500 && selW !== 1'b0; n++) tick(1);
        chk("select low", 32'h0, {31'h0, selW});
        for (n = 0; n < 3000 && loadW !== 1'b1; n++) tick(1);
        chk("cmd word", 32'h0312_3456, cmdSeen);
        chk("fast period", 32'd4, linkPer);
        chk("initDone low", 32'h0, {31'h0, initW});
        for (n = 0; n < 4000 && userMode !== 1'b1; n++) tick(1);
        chk("internal init", 32'h1, {31'h0, n >= 2980 && n <= 3000});
        chk("initDone high", 32'h1, {31'h0, initW});
        chk("link oe", 32'h0, {26'h0, linkOut} & 32'h15);
        $display("test boot done");
    endtask
    task automatic t_user_clk();
        bus(1, REG_CTRL, 32'h2);
        mode_select_pins <= 2'b00;
        pulse_req(1'b0);
        for (n = 0; n < 3000 && loadW !== 1'b1; n++) tick(1);
        chk("slow period", 32'd6, linkPer);
        pulse_req(1'b1);
        for (n = 0; n < 3000 && loadW !== 1'b1; n++) tick(1);
        tick(4000);
        chk("wait user clock", 32'h0, {31'h0, userMode});
        repeat (298) begin
            tick(8);
            uclk <= 1'b1;
            tick(8);
            uclk <= 1'b0;
        end
        tick(12);
        chk("before 299", 32'h0, {31'h0, userMode});
        uclk <= 1'b1;
        tick(12);
        uclk <= 1'b0;
        chk("after 299", 32'h1, {31'h0, userMode});
        $display("test user clock done");
    endtask
    task automatic t_error();
        bus(1, REG_CTRL, 32'h1);
        badSync <= 1'b1;
        pulse_req(1'b0);
        wait_error();
        badSync <= 1'b0;
        for (n = 0; n < 5000 && statW !== 1'b1; n++) tick(1);
        chk("restart time", 32'h1, {31'h0, n >= 3990 && n <= 4010});
        wait_user();
        bus(1, REG_CTRL, 32'h0);
        badSync <= 1'b1;
        pulse_req(1'b0);
        wait_error();
        badSync <= 1'b0;
        tick(5000);
        chk("no restart", 32'h0, {31'h0, statW});
        bus(0, REG_STATUS, 0);
        chk("STATUS error", 32'h0000_0102, rd);
        pulse_req(1'b0);
        wait_user();
        $display("test error done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #800000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        avsReq = '0;
        mode_select_pins = 2'b10;
        uclk = 1'b0;
        reqN = 1'b0;
        badSync = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        lastRise = 0;
        linkPer = 0;
        prevClk = 1'b1;
        tick(3);
        rst <= 1'b0;
        t_regs();
        t_boot();
        t_user_clk();
        t_error();
        report_and_stop();
    end
endmodule
